// ### rtl/dma_chan_pkg.sv
// Shared constants and types for the DMA channel and its transfer driver
package dma_chan_pkg;
   // Channel control register field positions
   localparam int CTL_SYNC_LOW_LSB  = 0;
   localparam int CTL_SYNC_LOW_W    = 5;
   localparam int CTL_FILL_EN_BIT   = 6;
   localparam int CTL_ENABLE_BIT    = 7;
   localparam int CTL_TRANSP_EN_BIT = 16;
   localparam int CTL_SYNC_HIGH_LSB = 19;
   localparam int CTL_SYNC_HIGH_W   = 2;
   localparam int CTL_PREFETCH_BIT  = 23;
   localparam int CTL_SIDE_SEL_BIT  = 24;
   localparam int CTL_NO_BUF_BIT    = 25;
   // Source/destination parameters register field positions
   localparam int SDP_PACK_BIT      = 13;
   localparam int SDP_BURST_LSB     = 14;
   localparam int SDP_BURST_W       = 2;
   // Reset values
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] SDP_RESET = 32'h0000_0000;
   // Data path
   localparam int DATA_W     = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int BURST_LEN  = 4;
   localparam int CNT_W      = 16;

   typedef enum logic [1:0] {
      SYNC_SOFT = 2'h0,
      SYNC_DST  = 2'h1,
      SYNC_SRC  = 2'h2
   } sync_mode_e;

   typedef enum logic [2:0] {
      CH_IDLE  = 3'h0,
      CH_RUN   = 3'h1,
      CH_ABORT = 3'h2,
      CH_DONE  = 3'h3
   } ch_state_e;
endpackage : dma_chan_pkg

// ### rtl/dma_link_if.sv
// Interface joining the channel to its read and write port targets
`timescale 1ns/1ns
interface dma_link_if;
   import dma_chan_pkg::*;
   // Read port
   logic              rd_req;
   logic              rd_ack;
   logic [DATA_W-1:0] rd_data;
   logic              rd_err;
   // Write port
   logic              wr_req;
   logic              wr_burst;
   logic              wr_last;
   logic [DATA_W-1:0] wr_data;
   logic              wr_ack;
   logic              wr_err;
   // Destination hardware request
   logic              hw_req;

   modport channel (
      output rd_req, wr_req, wr_burst, wr_last, wr_data,
      input  rd_ack, rd_data, rd_err, wr_ack, wr_err, hw_req
   );
   modport target (
      input  rd_req, wr_req, wr_burst, wr_last, wr_data,
      output rd_ack, rd_data, rd_err, wr_ack, wr_err, hw_req
   );
endinterface : dma_link_if

// ### rtl/dma_fifo.sv
// Parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dma_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             i_mclk,
   input  wire logic             i_rst_b,
   input  wire logic             i_flush,
   // Fill side
   input  wire logic             i_in_valid,
   input  wire logic [WIDTH-1:0] i_in_data,
   output logic                  o_in_ready,
   // Drain side
   output logic                  o_out_valid,
   output logic [WIDTH-1:0]      o_out_data,
   input  wire logic             i_out_ready,
   output logic [$clog2(DEPTH):0] o_level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
   logic [AW:0]      cnt_reg, cnt_next;
   logic             push, pop;

   assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_reg != '0);
   assign o_out_data  = mem_reg[rp_reg];
   assign o_level     = cnt_reg;
   assign push        = i_in_valid && o_in_ready;
   assign pop         = o_out_valid && i_out_ready;

   always_comb begin
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      cnt_next = cnt_reg;
      if (i_flush) begin
         wp_next  = '0;
         rp_next  = '0;
         cnt_next = '0;
      end else begin
         if (push) wp_next = (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         if (pop)  rp_next = (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (push && !i_flush) mem_reg[wp_reg] <= i_in_data;
   end
endmodule : dma_fifo

// ### rtl/dma_channel.sv
// DMA channel: read port to write port transfer with error abort and chaining
`timescale 1ns/1ns
module dma_channel #(
   parameter int BLOCK_MAX = 16
) (
   // Clock and reset
   input  wire logic                              i_mclk,
   input  wire logic                              i_rst_b,
   // Register write
   input  wire logic                              i_ctl_we,
   input  wire logic [31:0]                       i_ctl_wdata,
   input  wire logic                              i_sdp_we,
   input  wire logic [31:0]                       i_sdp_wdata,
   input  wire logic [dma_chan_pkg::CNT_W-1:0]    i_elem_count,
   input  wire logic                              i_status_clr,
   // Chain
   input  wire logic                              i_chain_member,
   input  wire logic                              i_link_enable,
   output logic                                   o_link_next,
   // Status
   output logic [31:0]                            o_ctl,
   output logic                                   o_rd_err_flag,
   output logic                                   o_wr_err_flag,
   output logic                                   o_aborted,
   output logic                                   o_graphics_on,
   output logic [1:0]                             o_sync_mode,
   // Ports
   dma_link_if.channel                            link
);
   import dma_chan_pkg::*;

   logic [31:0]      ctl_reg, ctl_next, sdp_reg, sdp_next;
   ch_state_e        st_reg, st_next;
   logic [CNT_W-1:0] rd_cnt_reg, rd_cnt_next, wr_cnt_reg, wr_cnt_next, total_reg, total_next;
   logic             rd_err_reg, rd_err_next, wr_err_reg, wr_err_next;
   logic             aborted_reg, aborted_next, reused_reg, reused_next, link_reg, link_next;
   logic [2:0]       beat_reg, beat_next;
   logic             rd_pend_reg, rd_pend_next;
   logic             f_in_ready, f_out_valid, flush;
   logic [DATA_W-1:0] f_out_data;
   logic             enable, sync_zero, soft_sync, dst_sync, burst_mode, no_buf, last_wr, wr_go;
   logic             gfx_reg, gfx_next;
   logic [1:0]       mode_reg, mode_next;

   function automatic logic sync_is_zero(input logic [31:0] c);
      return c[CTL_SYNC_LOW_LSB +: CTL_SYNC_LOW_W] == '0 && c[CTL_SYNC_HIGH_LSB +: CTL_SYNC_HIGH_W] == '0;
   endfunction : sync_is_zero

   assign enable    = ctl_reg[CTL_ENABLE_BIT];
   assign sync_zero = sync_is_zero(ctl_reg);
   assign soft_sync = sync_zero;
   assign dst_sync  = !sync_zero && !ctl_reg[CTL_SIDE_SEL_BIT];
   assign no_buf    = ctl_reg[CTL_NO_BUF_BIT];
   // Burst only when never aborted and reused
   assign burst_mode = sdp_reg[SDP_PACK_BIT] && (sdp_reg[SDP_BURST_LSB +: SDP_BURST_W] != '0) && !reused_reg;
   assign last_wr   = (wr_cnt_reg + 1'b1 == total_reg);
   assign wr_go     = f_out_valid && (soft_sync || !dst_sync || link.hw_req || ctl_reg[CTL_PREFETCH_BIT]);
   assign flush     = (st_reg == CH_ABORT);

   dma_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_mclk     (i_mclk),
      .i_rst_b    (i_rst_b),
      .i_flush    (flush),
      .i_in_valid (link.rd_ack && rd_pend_reg),
      .i_in_data  (link.rd_data),
      .o_in_ready (f_in_ready),
      .o_out_valid(f_out_valid),
      .o_out_data (f_out_data),
      .i_out_ready(link.wr_ack),
      .o_level    ()
   );

   always_comb begin
      ctl_next     = ctl_reg;
      sdp_next     = sdp_reg;
      st_next      = st_reg;
      rd_cnt_next  = rd_cnt_reg;
      wr_cnt_next  = wr_cnt_reg;
      total_next   = total_reg;
      rd_err_next  = rd_err_reg;
      wr_err_next  = wr_err_reg;
      aborted_next = aborted_reg;
      reused_next  = reused_reg;
      link_next    = 1'b0;
      beat_next    = beat_reg;
      rd_pend_next = rd_pend_reg;
      if (i_sdp_we) sdp_next = i_sdp_wdata;
      if (i_ctl_we) begin
         ctl_next = i_ctl_wdata;
         // Non-head chain members ignore direct enable
         if (i_chain_member) ctl_next[CTL_ENABLE_BIT] = ctl_reg[CTL_ENABLE_BIT] && i_ctl_wdata[CTL_ENABLE_BIT];
      end
      if (i_link_enable && i_chain_member) begin
         ctl_next[CTL_ENABLE_BIT] = 1'b1;
         if (aborted_reg) reused_next = 1'b1;
      end
      if (i_status_clr) begin
         rd_err_next = 1'b0;
         wr_err_next = 1'b0;
      end
      unique case (st_reg)
         CH_IDLE: begin
            if (ctl_next[CTL_ENABLE_BIT] && !enable) begin
               st_next     = CH_RUN;
               rd_cnt_next = '0;
               wr_cnt_next = '0;
               beat_next   = '0;
               total_next  = (i_elem_count == '0) ? CNT_W'(BLOCK_MAX) : i_elem_count;
            end
         end
         CH_RUN: begin
            if (link.rd_ack && rd_pend_reg) begin
               rd_cnt_next  = rd_cnt_reg + 1'b1;
               rd_pend_next = 1'b0;
            end else if (!rd_pend_reg && f_in_ready && rd_cnt_reg != total_reg) begin
               rd_pend_next = 1'b1;
            end
            if (link.wr_ack) begin
               wr_cnt_next = wr_cnt_reg + 1'b1;
               beat_next   = beat_reg + 1'b1;
            end
            if (link.rd_err) begin
               rd_err_next = 1'b1;
               st_next     = CH_ABORT;
            end
            if (link.wr_err) begin
               wr_err_next = 1'b1;
               if (last_wr && (dst_sync || no_buf)) st_next = CH_DONE;
               else st_next = CH_ABORT;
            end else if (link.wr_ack && last_wr) begin
               st_next = CH_DONE;
            end
            if (!ctl_next[CTL_ENABLE_BIT]) st_next = CH_ABORT;
         end
         CH_ABORT: begin
            ctl_next[CTL_ENABLE_BIT] = 1'b0;
            aborted_next = 1'b1;
            rd_pend_next = 1'b0;
            st_next      = CH_IDLE;
         end
         CH_DONE: begin
            // Errored channel waits for software disable
            if (!(wr_err_reg && (dst_sync || no_buf))) ctl_next[CTL_ENABLE_BIT] = 1'b0;
            if (!ctl_next[CTL_ENABLE_BIT]) begin
               link_next = 1'b1;
               st_next   = CH_IDLE;
            end
         end
         default: st_next = CH_IDLE;
      endcase
      // Graphics off when both enables zero
      gfx_next = ctl_next[CTL_FILL_EN_BIT] || ctl_next[CTL_TRANSP_EN_BIT];
      if (sync_is_zero(ctl_next)) mode_next = SYNC_SOFT;
      else if (!ctl_next[CTL_SIDE_SEL_BIT]) mode_next = SYNC_DST;
      else mode_next = SYNC_SRC;
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctl_reg     <= CTL_RESET;
         sdp_reg     <= SDP_RESET;
         st_reg      <= CH_IDLE;
         rd_cnt_reg  <= '0;
         wr_cnt_reg  <= '0;
         total_reg   <= '0;
         rd_err_reg  <= 1'b0;
         wr_err_reg  <= 1'b0;
         aborted_reg <= 1'b0;
         reused_reg  <= 1'b0;
         link_reg    <= 1'b0;
         beat_reg    <= '0;
         rd_pend_reg <= 1'b0;
         gfx_reg     <= 1'b0;
         mode_reg    <= SYNC_SOFT;
      end else begin
         ctl_reg     <= ctl_next;
         sdp_reg     <= sdp_next;
         st_reg      <= st_next;
         rd_cnt_reg  <= rd_cnt_next;
         wr_cnt_reg  <= wr_cnt_next;
         total_reg   <= total_next;
         rd_err_reg  <= rd_err_next;
         wr_err_reg  <= wr_err_next;
         aborted_reg <= aborted_next;
         reused_reg  <= reused_next;
         link_reg    <= link_next;
         beat_reg    <= beat_next;
         rd_pend_reg <= rd_pend_next;
         gfx_reg     <= gfx_next;
         mode_reg    <= mode_next;
      end
   end

   // Outputs
   assign o_ctl         = ctl_reg;
   assign o_rd_err_flag = rd_err_reg;
   assign o_wr_err_flag = wr_err_reg;
   assign o_aborted     = aborted_reg;
   assign o_link_next   = link_reg;
   assign o_graphics_on = gfx_reg;
   assign o_sync_mode   = mode_reg;
   assign link.rd_req   = rd_pend_reg;
   assign link.wr_req   = (st_reg == CH_RUN) && wr_go;
   assign link.wr_data  = f_out_data;
   assign link.wr_burst = burst_mode;
   assign link.wr_last  = burst_mode ? (beat_reg[1:0] == 2'(BURST_LEN-1)) || last_wr : 1'b1;
endmodule : dma_channel

// ### rtl/dma_target.sv
// Interconnect targets on the read and write ports of the channel
`timescale 1ns/1ns
module dma_target #(
   parameter int DW = dma_chan_pkg::DATA_W
) (
   // Clock and reset
   input  wire logic          i_mclk,
   input  wire logic          i_rst_b,
   // User side
   input  wire logic          i_rd_err_inject,
   input  wire logic          i_wr_err_inject,
   input  wire logic          i_hw_req,
   input  wire logic [DW-1:0] i_rd_data,
   output logic [DW-1:0]      o_wr_data,
   output logic               o_wr_valid,
   output logic               o_wr_burst,
   // Ports
   dma_link_if.target         link
);
   import dma_chan_pkg::*;
   logic          rd_ack_reg, rd_ack_next, wr_ack_reg, wr_ack_next;
   logic          rd_err_reg, rd_err_next, wr_err_reg, wr_err_next, hw_reg, hw_next;
   logic [DW-1:0] rd_data_reg, rd_data_next, wd_reg, wd_next;
   logic          wv_reg, wv_next, wb_reg, wb_next;
   logic          rd_arm_reg, rd_arm_next, wr_arm_reg, wr_arm_next, rd_free, wr_free;

   always_comb begin
      // Injection arms an error for the next response on that port
      rd_arm_next  = rd_arm_reg || i_rd_err_inject;
      wr_arm_next  = wr_arm_reg || i_wr_err_inject;
      rd_free      = link.rd_req && !rd_ack_reg && !rd_err_reg;
      wr_free      = link.wr_req && !wr_ack_reg && !wr_err_reg;
      rd_ack_next  = rd_free && !rd_arm_next;
      rd_err_next  = rd_free && rd_arm_next;
      if (rd_err_next) rd_arm_next = 1'b0;
      rd_data_next = i_rd_data;
      wr_ack_next  = wr_free && !wr_arm_next;
      wr_err_next  = wr_free && wr_arm_next;
      if (wr_err_next) wr_arm_next = 1'b0;
      wd_next      = link.wr_data;
      wv_next      = wr_ack_next;
      wb_next      = link.wr_burst;
      hw_next      = i_hw_req;
   end

   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rd_ack_reg  <= 1'b0;
         rd_err_reg  <= 1'b0;
         rd_data_reg <= '0;
         wr_ack_reg  <= 1'b0;
         wr_err_reg  <= 1'b0;
         wd_reg      <= '0;
         wv_reg      <= 1'b0;
         wb_reg      <= 1'b0;
         hw_reg      <= 1'b0;
         rd_arm_reg  <= 1'b0;
         wr_arm_reg  <= 1'b0;
      end else begin
         rd_ack_reg  <= rd_ack_next;
         rd_err_reg  <= rd_err_next;
         rd_data_reg <= rd_data_next;
         wr_ack_reg  <= wr_ack_next;
         wr_err_reg  <= wr_err_next;
         wd_reg      <= wd_next;
         wv_reg      <= wv_next;
         wb_reg      <= wb_next;
         hw_reg      <= hw_next;
         rd_arm_reg  <= rd_arm_next;
         wr_arm_reg  <= wr_arm_next;
      end
   end

   assign link.rd_ack  = rd_ack_reg;
   assign link.rd_err  = rd_err_reg;
   assign link.rd_data = rd_data_reg;
   assign link.wr_ack  = wr_ack_reg;
   assign link.wr_err  = wr_err_reg;
   assign link.hw_req  = hw_reg;
   assign o_wr_data    = wd_reg;
   assign o_wr_valid   = wv_reg;
   assign o_wr_burst   = wb_reg;
endmodule : dma_target

// ### dv/dma_link_sva.sv
// Concurrent checks on the channel link and status outputs
`timescale 1ns/1ns
module dma_link_sva
   import dma_chan_pkg::*;
(
   // Clock and reset
   input wire logic              i_mclk,
   input wire logic              i_rst_b,
   // Link
   input wire logic              rd_req,
   input wire logic              rd_ack,
   input wire logic              rd_err,
   input wire logic              wr_req,
   input wire logic              wr_burst,
   input wire logic              wr_last,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic              wr_err,
   input wire logic              wr_ack,
   // Channel status
   input wire logic [31:0]       o_ctl,
   input wire logic              o_wr_err_flag,
   input wire logic              o_aborted,
   input wire logic              o_graphics_on,
   input wire logic [1:0]        o_sync_mode,
   input wire logic              o_link_next
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b);

   sequence mid_wr_err;
      wr_req && wr_err && !wr_last;
   endsequence
   sequence chan_off;
      !o_ctl[CTL_ENABLE_BIT] && o_aborted;
   endsequence

   rd_hold_a: assert property (rd_req && !rd_ack && !rd_err |=> rd_req)
      else $error("read request dropped before answer");
   wr_hold_a: assert property (wr_req && !wr_ack && !wr_err |=> wr_req && $stable(wr_data))
      else $error("write request changed before answer");
   single_last_a: assert property (wr_req && !wr_burst |-> wr_last)
      else $error("single write without last mark");
   wr_flag_a: assert property (wr_req && wr_err |=> o_wr_err_flag)
      else $error("write error not recorded");
   abort_off_a: assert property (mid_wr_err |-> ##[1:3] chan_off)
      else $error("channel still enabled after write error");
   graph_off_a: assert property ((!o_ctl[CTL_FILL_EN_BIT] && !o_ctl[CTL_TRANSP_EN_BIT]) [*2] |-> !o_graphics_on)
      else $error("graphics on with both enables clear");
   soft_sync_a: assert property ((o_ctl[4:0] == 5'h0 && o_ctl[20:19] == 2'h0) [*2] |-> o_sync_mode == 2'h0)
      else $error("zero sync fields not software sync");
   dst_sync_a: assert property ((!o_ctl[24] && o_ctl[23] && o_ctl[4:0] != 5'h0) [*2] |-> o_sync_mode == 2'h1)
      else $error("destination prefetch mode not selected");
   link_pulse_a: assert property (o_link_next |=> !o_link_next)
      else $error("link pulse longer than one cycle");
endmodule : dma_link_sva

// ### dv/dma_channel_error_abort_tb.sv
// Self-checking bench for the channel and its targets joined by the link
`timescale 1ns/1ns
module dma_channel_error_abort_tb;
   import dma_chan_pkg::*;
   logic              i_mclk, i_rst_b, ctl_we, sdp_we, status_clr, chain_member, link_enable;
   logic              rd_inj, wr_inj, hw_req, mon_on, link_next, rd_flag, wr_flag, aborted, gfx;
   logic              wr_valid, wr_burst_seen;
   logic [31:0]       ctl_wdata, sdp_wdata, ctl;
   logic [DATA_W-1:0] rd_data, wr_data_seen;
   logic [CNT_W-1:0]  elem_count;
   logic [1:0]        sync_mode;
   logic [DATA_W:0]   exp_q[$];
   int                bad_count, compares;
   logic [31:0]       mode_ctl [3] = '{32'h0000_0080, 32'h0080_0081, 32'h0088_0080};
   logic [1:0]        mode_exp [3] = '{SYNC_SOFT, SYNC_DST, SYNC_DST};

   dma_link_if link();
   dma_channel #(.BLOCK_MAX(16)) i_dma_channel (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_ctl_we(ctl_we),
      .i_ctl_wdata(ctl_wdata), .i_sdp_we(sdp_we), .i_sdp_wdata(sdp_wdata), .i_elem_count(elem_count),
      .i_status_clr(status_clr), .i_chain_member(chain_member), .i_link_enable(link_enable),
      .o_link_next(link_next), .o_ctl(ctl), .o_rd_err_flag(rd_flag), .o_wr_err_flag(wr_flag),
      .o_aborted(aborted), .o_graphics_on(gfx), .o_sync_mode(sync_mode), .link(link));
   dma_target i_dma_target (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_rd_err_inject(rd_inj),
      .i_wr_err_inject(wr_inj), .i_hw_req(hw_req), .i_rd_data(rd_data), .o_wr_data(wr_data_seen),
      .o_wr_valid(wr_valid), .o_wr_burst(wr_burst_seen), .link(link));
   dma_link_sva i_dma_link_sva (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .rd_req(link.rd_req),
      .rd_ack(link.rd_ack), .rd_err(link.rd_err), .wr_req(link.wr_req), .wr_burst(link.wr_burst),
      .wr_last(link.wr_last), .wr_data(link.wr_data), .wr_err(link.wr_err), .wr_ack(link.wr_ack),
      .o_ctl(ctl), .o_wr_err_flag(wr_flag), .o_aborted(aborted), .o_graphics_on(gfx),
      .o_sync_mode(sync_mode), .o_link_next(link_next));

   initial begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end

   task automatic summarize();
      $display("Mismatches %0d, compares %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic cmp(input logic [DATA_W:0] got, input logic [DATA_W:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // Written beat against the oldest noted beat; an unnoted beat always fails
   task automatic cmp_beat(input logic [DATA_W:0] got);
      if (exp_q.size() == 0) cmp(got, 'x);
      else cmp(got, exp_q.pop_front());
   endtask : cmp_beat

   task automatic pulse_ctl(input logic [31:0] v);
      @(negedge i_mclk);
      ctl_wdata = v;
      ctl_we = 1'b1;
      @(negedge i_mclk);
      ctl_we = 1'b0;
   endtask : pulse_ctl

   // Loads a block, notes expected beats, then starts it by write or by link
   task automatic run(input logic [31:0] c, input logic [31:0] s, input int n, input logic by_link,
                      input logic burst);
      @(negedge i_mclk);
      sdp_wdata = s;
      sdp_we = 1'b1;
      elem_count = n[CNT_W-1:0];
      rd_data = $urandom;
      @(negedge i_mclk);
      sdp_we = 1'b0;
      for (int k = 0; k < n && mon_on; k++) exp_q.push_back({burst, rd_data});
      pulse_ctl(c);
      if (by_link) begin
         link_enable = 1'b1;
         @(negedge i_mclk);
         link_enable = 1'b0;
      end
   endtask : run

   task automatic wait_flag(input int sel);
      logic [3:0] f;
      for (int k = 0; k < 400; k++) begin
         f = {rd_flag, wr_flag, aborted, link_next};
         if (f[sel] === 1'b1) break;
         @(negedge i_mclk);
      end
      cmp(f[sel], 1'b1);
   endtask : wait_flag

   task automatic pulse_inj(input logic wr);
      @(negedge i_mclk);
      if (wr) wr_inj = 1'b1;
      else rd_inj = 1'b1;
      @(negedge i_mclk);
      {rd_inj, wr_inj} = 2'b00;
   endtask : pulse_inj

   always @(negedge i_mclk) begin
      if (mon_on && wr_valid === 1'b1) cmp_beat({wr_burst_seen, wr_data_seen});
   end

   initial begin
      #(4000 * 50);
      bad_count++;
      summarize();
   end

   initial begin
      {ctl_we, sdp_we, status_clr, chain_member, link_enable, rd_inj, wr_inj, hw_req} = '0;
      {ctl_wdata, sdp_wdata, rd_data, elem_count, bad_count, compares} = '0;
      mon_on = 1'b1;
      i_rst_b = 1'b0;
      void'($urandom(67));
      repeat (2) @(posedge i_mclk);
      @(negedge i_mclk);
      i_rst_b = 1'b1;
      // Sync modes with burst and pack, graphics off; then graphics on from each enable alone
      for (int m = 0; m < 3; m++) begin
         hw_req = (m != 0);
         run(mode_ctl[m], 32'h0000_6000, 8, 1'b0, 1'b1);
         wait_flag(0);
         cmp(sync_mode, mode_exp[m]);
         cmp(gfx, 1'b0);
         cmp(exp_q.size(), 0);
      end
      hw_req = 1'b0;
      foreach (mode_ctl[g]) begin
         pulse_ctl(g == 0 ? 32'h0000_0040 : (g == 1 ? 32'h0001_0000 : 32'h0000_0000));
         repeat (2) @(negedge i_mclk);
         cmp(gfx, g < 2);
         pulse_ctl(32'h0);
      end
      // Write error in mid-burst: clean abort and self-disable
      mon_on = 1'b0;
      pulse_inj(1'b1);
      run(32'h0000_0080, 32'h0000_6000, 8, 1'b0, 1'b1);
      wait_flag(1);
      cmp(wr_flag, 1'b1);
      cmp(ctl[CTL_ENABLE_BIT], 1'b0);
      @(negedge i_mclk);
      status_clr = 1'b1;
      @(negedge i_mclk);
      status_clr = 1'b0;
      @(negedge i_mclk);
      cmp(wr_flag, 1'b0);
      // Chained reuse: direct enable refused, link enable gives singles
      chain_member = 1'b1;
      pulse_ctl(32'h0000_0080);
      repeat (3) @(negedge i_mclk);
      cmp(ctl[CTL_ENABLE_BIT], 1'b0);
      mon_on = 1'b1;
      run(32'h0, 32'h0000_6000, 4, 1'b1, 1'b0);
      wait_flag(0);
      cmp(exp_q.size(), 0);
      // Last-element error with no-buffer bit keeps enable until software clears it
      chain_member = 1'b0;
      mon_on = 1'b0;
      pulse_inj(1'b1);
      run(32'h0200_0080, 32'h0, 1, 1'b0, 1'b0);
      wait_flag(2);
      repeat (3) @(negedge i_mclk);
      cmp(ctl[CTL_ENABLE_BIT], 1'b1);
      pulse_ctl(32'h0);
      @(negedge i_mclk);
      cmp(ctl[CTL_ENABLE_BIT], 1'b0);
      // Read error recorded
      pulse_inj(1'b0);
      run(32'h0000_0080, 32'h0, 4, 1'b0, 1'b0);
      wait_flag(3);
      summarize();
   end
endmodule : dma_channel_error_abort_tb
